/* logic/irq_cmd_pkg.sv */
// Constants shared by the interrupt mask and command register slice
package irq_cmd_pkg;
  // Register byte offsets
  localparam logic [11:0] ENABLE_MASK_OFS  = 12'h110;
  localparam logic [11:0] LINE_STATUS_OFS  = 12'h114;
  localparam logic [11:0] ENABLE_CMD_OFS   = 12'h120;
  localparam logic [11:0] DISABLE_CMD_OFS  = 12'h124;
  localparam logic [11:0] PEND_CLEAR_OFS   = 12'h128;
  localparam logic [11:0] PEND_SET_OFS     = 12'h12C;
  localparam logic [11:0] END_TREAT_OFS    = 12'h130;
  localparam logic [11:0] PEND_STATUS_OFS  = 12'h10C;
  localparam logic [11:0] EVENT_STATUS_OFS = 12'h140;
  localparam logic [11:0] EVENT_MASK_OFS   = 12'h144;
  localparam logic [11:0] LEVEL_OFS        = 12'h148;
  // Reset values
  localparam logic [31:0] ENABLE_MASK_RST  = 32'h0000_0000;
  localparam logic [31:0] PENDING_RST      = 32'h0000_0000;
  localparam logic [2:0]  EVENT_RST        = 3'h0;
  // Bits 21 and 22 carry no source
  localparam logic [31:0] USED_SOURCES     = 32'hFF9F_FFFF;
  // Source bit positions
  localparam int FAST_BIT      = 0;
  localparam int SOFTWARE_BIT  = 1;
  localparam int SERIAL0_BIT   = 2;
  localparam int SERIAL_PERIPH = 5;
  localparam int TIMER0_BIT    = 6;
  localparam int WATCHDOG_BIT  = 12;
  localparam int IO_PORT_A_BIT = 13;
  localparam int CONVERTER_BIT = 15;
  localparam int OUT_CONV_BIT  = 17;
  localparam int CALENDAR_BIT  = 19;
  localparam int POWER_BIT     = 20;
  localparam int SLOW_CLK_BIT  = 23;
  localparam int EXT_LINE5_BIT = 24;
  localparam int DBG_TX_BIT    = 30;
  localparam int DBG_RX_BIT    = 31;
  // Line status and event status fields
  localparam int LINE_FAST_POS = 0;
  localparam int LINE_NORM_POS = 1;
  localparam int EV_END_POS    = 0;
  localparam int EV_NORM_POS   = 1;
  localparam int EV_OVF_POS    = 2;
  // Priority levels and level stack
  localparam int LEVEL_W       = 3;
  localparam int STACK_DEPTH   = 8;
endpackage : irq_cmd_pkg

/* logic/resolve_if.sv */
// Request and answer between the register slice and the priority resolver
`timescale 1ns/1ns
interface resolve_if;
  logic [31:0]                          req;
  logic [32*irq_cmd_pkg::LEVEL_W-1:0]   prio;
  logic                                 valid;
  logic [irq_cmd_pkg::LEVEL_W-1:0]      level;
  modport slice (output req, output prio, input valid, input level);
  modport res   (input req, input prio, output valid, output level);
endinterface : resolve_if

/* logic/prio_resolve.sv */
// Finds the highest priority level among the requesting normal sources
`timescale 1ns/1ns
module prio_resolve (
  resolve_if.res rif
);
  localparam int LW = irq_cmd_pkg::LEVEL_W;

  logic [31:0][LW-1:0] lvl;

  // Per-source level, forced to zero when not requesting
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_src
      assign lvl[g] = rif.req[g] ? rif.prio[g*LW +: LW] : '0;
    end
  endgenerate

  // Maximum over the normal sources; the fast source never competes here
  always_comb begin
    logic [LW-1:0] best;
    best = '0;
    for (int i = 1; i < 32; i++) begin
      if (rif.req[i] && lvl[i] > best) begin
        best = lvl[i];
      end
    end
    rif.level = best;
    rif.valid = |rif.req[31:1];
  end
endmodule : prio_resolve

/* logic/irq_cmd_regs.sv */
// Interrupt mask, pending command and end-of-treatment register slice
//
// Operation
// - Read-only enable mask, one bit per source, cleared by reset.
// - Bits 0..14: fast, software, serial, periph, timers, watchdog, I/O ports.
// - Bits 15..31: converters, calendar, power, slow clock, external, debug; 21,22 unused.
// - Core line status: bit 0 fast line, bit 1 normal line; reset zero.
// - Enable command sets mask bits written one, others unchanged.
// - Disable command clears mask bits written one, others unchanged.
// - Clear command removes pending state of sources written one.
// - Set command makes sources written one pending.
// - Any end-of-treatment write signals end of handling; data ignored.
// - End-of-treatment pops level stack; reasserts normal line if outranked.
// - Pending bit reads one while pending; command writes act on it.
`timescale 1ns/1ns
module irq_cmd_regs (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // APB slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // Sources, already qualified triggers, and their priority levels
  input  wire logic [31:0]              source_trig_in,
  input  wire logic [32*3-1:0]          source_prio_in,
  // Acknowledge pulse from the vector read logic
  input  wire logic                     vector_ack_in,
  // Lines to the processor core and state for the rest of the controller
  output logic                          fast_request_out,
  output logic                          normal_request_out,
  output logic      [31:0]              pending_status_out,
  output logic      [2:0]               current_level_out,
  output logic                          irq_out
);
  localparam int LW = irq_cmd_pkg::LEVEL_W;
  localparam int SD = irq_cmd_pkg::STACK_DEPTH;

  typedef struct packed {
    logic [31:0]         mask;
    logic [31:0]         pend;
    logic                fast;
    logic                normal;
    logic [SD-1:0][LW-1:0] stack;
    logic [3:0]          sp;
    logic [2:0]          cur;
    logic [2:0]          ev_stat;
    logic [2:0]          ev_mask;
    logic                irq;
    logic [31:0]         rdata;
    logic                ready;
    logic                err;
  } state_t;

  state_t     s_q;
  state_t     s_d;
  logic [1:0] rst_sync_q;
  logic       rst_n;

  resolve_if rif ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Resolver sees only enabled pending sources
  assign rif.req  = s_q.pend & s_q.mask;
  assign rif.prio = source_prio_in;

  prio_resolve u_resolve (
    .rif (rif)
  );

  // Bus decode; a transfer completes at the edge where ready is high
  logic        acc;
  logic        done;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_val;
  logic [2:0]  cur_lvl;
  logic        stack_empty;

  assign acc         = psel_in && penable_in;
  assign done        = acc && s_q.ready;
  assign wr          = done && pwrite_in;
  assign stack_empty = (s_q.sp == 4'h0);
  assign cur_lvl     = stack_empty ? 3'h0 : s_q.stack[s_q.sp[2:0] - 3'h1];

  // Read mux and address map
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr_in)
      irq_cmd_pkg::ENABLE_MASK_OFS:  rd_val = s_q.mask;
      irq_cmd_pkg::LINE_STATUS_OFS:  rd_val = {30'h0, s_q.normal, s_q.fast};
      irq_cmd_pkg::PEND_STATUS_OFS:  rd_val = s_q.pend;
      irq_cmd_pkg::EVENT_STATUS_OFS: rd_val = {29'h0, s_q.ev_stat};
      irq_cmd_pkg::EVENT_MASK_OFS:   rd_val = {29'h0, s_q.ev_mask};
      irq_cmd_pkg::LEVEL_OFS:        rd_val = {28'h0, s_q.sp[3:0]} << 4 | {29'h0, cur_lvl};
      irq_cmd_pkg::ENABLE_CMD_OFS,
      irq_cmd_pkg::DISABLE_CMD_OFS,
      irq_cmd_pkg::PEND_CLEAR_OFS,
      irq_cmd_pkg::PEND_SET_OFS,
      irq_cmd_pkg::END_TREAT_OFS:    rd_val = 32'h0000_0000;
      default:                       mapped = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    logic [31:0] clr;
    logic [31:0] set;
    logic        eot;
    logic        push;
    logic [3:0]  sp_n;
    logic [2:0]  lvl_n;
    logic [2:0]  ev;
    s_d  = s_q;
    clr  = 32'h0000_0000;
    set  = 32'h0000_0000;
    eot  = 1'b0;
    push = 1'b0;
    ev   = 3'h0;
    sp_n  = s_q.sp;
    lvl_n = 3'h0;

    // One wait state, then the answer
    s_d.ready = acc && !s_q.ready;
    s_d.err   = acc && !s_q.ready && !mapped;
    s_d.rdata = (acc && !s_q.ready && !pwrite_in) ? rd_val : 32'h0000_0000;

    // Command writes; unused positions are masked off
    if (wr) begin
      unique case (paddr_in)
        irq_cmd_pkg::ENABLE_CMD_OFS:
          s_d.mask = s_q.mask | (pwdata_in & irq_cmd_pkg::USED_SOURCES);
        irq_cmd_pkg::DISABLE_CMD_OFS:
          s_d.mask = s_q.mask & ~pwdata_in;
        irq_cmd_pkg::PEND_CLEAR_OFS:
          clr = pwdata_in;
        irq_cmd_pkg::PEND_SET_OFS:
          set = pwdata_in & irq_cmd_pkg::USED_SOURCES;
        irq_cmd_pkg::END_TREAT_OFS:
          eot = 1'b1;
        irq_cmd_pkg::EVENT_STATUS_OFS:
          s_d.ev_stat = s_q.ev_stat & ~pwdata_in[2:0];
        irq_cmd_pkg::EVENT_MASK_OFS:
          s_d.ev_mask = pwdata_in[2:0];
        default: ;
      endcase
    end

    // Triggers and set commands win over a clear in the same cycle
    s_d.pend = ((s_q.pend & ~clr) | set |
                (source_trig_in & irq_cmd_pkg::USED_SOURCES));

    // Level stack: acknowledge pushes, end of treatment pops
    push  = vector_ack_in && rif.valid;
    if (eot && !stack_empty) begin
      sp_n = s_q.sp - 4'h1;
    end else if (push) begin
      if (s_q.sp == 4'(SD)) begin
        ev[irq_cmd_pkg::EV_OVF_POS] = 1'b1;
      end else begin
        s_d.stack[s_q.sp[2:0]] = rif.level;
        sp_n = s_q.sp + 4'h1;
      end
    end
    s_d.sp = sp_n;
    lvl_n  = (sp_n == 4'h0) ? 3'h0 : s_d.stack[sp_n[2:0] - 3'h1];
    // Registered copy so the level output leaves a flop, not the stack mux
    s_d.cur = lvl_n;

    // Lines to the core; the normal line rises again when outranked
    s_d.fast   = s_q.pend[irq_cmd_pkg::FAST_BIT] && s_q.mask[irq_cmd_pkg::FAST_BIT];
    s_d.normal = !push && rif.valid &&
                 ((sp_n == 4'h0) || rif.level > lvl_n);

    // Sticky events; a new event beats a clear in the same cycle
    ev[irq_cmd_pkg::EV_END_POS]  = eot;
    ev[irq_cmd_pkg::EV_NORM_POS] = s_d.normal && !s_q.normal;
    s_d.ev_stat = s_d.ev_stat | ev;
    s_d.irq     = |(s_d.ev_stat & s_d.ev_mask);
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.mask    <= irq_cmd_pkg::ENABLE_MASK_RST;
      s_q.pend    <= irq_cmd_pkg::PENDING_RST;
      s_q.ev_stat <= irq_cmd_pkg::EVENT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign prdata_out         = s_q.rdata;
  assign pready_out         = s_q.ready;
  assign pslverr_out        = s_q.err;
  assign fast_request_out   = s_q.fast;
  assign normal_request_out = s_q.normal;
  assign pending_status_out = s_q.pend;
  assign current_level_out  = s_q.cur;
  assign irq_out            = s_q.irq;

  // Completed write to a given offset
  sequence write_at(logic [11:0] ofs);
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == ofs;
  endsequence

  sequence read_at(logic [11:0] ofs);
    psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == ofs;
  endsequence

  mask_after_reset_a: assert property (
    @(posedge clk_in) $rose(rst_n) |-> s_q.mask == 32'h0000_0000 && !fast_request_out)
    else $error("mask not clear after reset");

  mask_enable_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    write_at(irq_cmd_pkg::ENABLE_CMD_OFS) |=>
      ((s_q.mask & $past(pwdata_in) & irq_cmd_pkg::USED_SOURCES) ==
       ($past(pwdata_in) & irq_cmd_pkg::USED_SOURCES)) &&
      ((s_q.mask & ~$past(pwdata_in)) == ($past(s_q.mask) & ~$past(pwdata_in))))
    else $error("enable command did not set mask bits");

  mask_disable_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    write_at(irq_cmd_pkg::DISABLE_CMD_OFS) |=>
      (s_q.mask & $past(pwdata_in)) == 32'h0000_0000 &&
      (s_q.mask | $past(pwdata_in)) == ($past(s_q.mask) | $past(pwdata_in)))
    else $error("disable command did not clear mask bits");

  pend_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    write_at(irq_cmd_pkg::PEND_CLEAR_OFS) |=>
      (s_q.pend & $past(pwdata_in) & ~$past(source_trig_in)) == 32'h0000_0000)
    else $error("clear command left a source pending");

  pend_set_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    write_at(irq_cmd_pkg::PEND_SET_OFS) |=>
      (pending_status_out & $past(pwdata_in) & irq_cmd_pkg::USED_SOURCES) ==
      ($past(pwdata_in) & irq_cmd_pkg::USED_SOURCES))
    else $error("set command did not make source pending");

  unused_bits_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    s_q.mask[22:21] == 2'h0 && pending_status_out[22:21] == 2'h0)
    else $error("unused source position became set");

  line_status_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    read_at(irq_cmd_pkg::LINE_STATUS_OFS) |=>
      prdata_out == {30'h0, $past(normal_request_out), $past(fast_request_out)})
    else $error("core line status read mismatch");

  fast_line_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    ##1 fast_request_out == ($past(s_q.pend[0]) && $past(s_q.mask[0])))
    else $error("fast line does not follow enabled pending fast source");

  eot_pop_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    write_at(irq_cmd_pkg::END_TREAT_OFS) ##0 (s_q.sp != 4'h0) |=>
      s_q.sp == $past(s_q.sp) - 4'h1 && s_q.ev_stat[irq_cmd_pkg::EV_END_POS])
    else $error("end of treatment did not pop the level stack");

  apb_wait_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (psel_in && !penable_in) ##1 (psel_in && penable_in) |-> !pready_out ##1 pready_out)
    else $error("ready not given after one wait state");

  // Acknowledge that really pushes; an end-of-treatment write on a non-empty stack would win
  sequence ack_taken;
    vector_ack_in && rif.valid && !(wr && paddr_in == irq_cmd_pkg::END_TREAT_OFS);
  endsequence

  stack_push_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    ack_taken ##0 (s_q.sp != 4'h8) |=>
      s_q.sp == $past(s_q.sp) + 4'h1 && !normal_request_out)
    else $error("acknowledge did not push the level stack");

  norm_event_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    $rose(normal_request_out) |-> s_q.ev_stat[irq_cmd_pkg::EV_NORM_POS])
    else $error("normal line rise not recorded");

  irq_level_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    irq_out == |(s_q.ev_stat & s_q.ev_mask))
    else $error("interrupt output disagrees with unmasked events");

  unmapped_err_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    psel_in && penable_in && !pready_out && !mapped |=> pready_out && pslverr_out)
    else $error("unmapped access gave no error");

  rdata_idle_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero outside an answer");

  mask_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    read_at(irq_cmd_pkg::ENABLE_MASK_OFS) |=> prdata_out == $past(s_q.mask))
    else $error("mask register read mismatch");

  pend_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    read_at(irq_cmd_pkg::PEND_STATUS_OFS) |=> prdata_out == $past(pending_status_out))
    else $error("pending register read mismatch");

  trig_pend_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (source_trig_in & irq_cmd_pkg::USED_SOURCES) != 32'h0000_0000 |=>
      (pending_status_out & $past(source_trig_in) & irq_cmd_pkg::USED_SOURCES) ==
      ($past(source_trig_in) & irq_cmd_pkg::USED_SOURCES))
    else $error("trigger did not make source pending");

  eot_empty_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    write_at(irq_cmd_pkg::END_TREAT_OFS) ##0 (s_q.sp == 4'h0 && !vector_ack_in) |=>
      s_q.sp == 4'h0 && s_q.ev_stat[irq_cmd_pkg::EV_END_POS])
    else $error("end of treatment on empty stack misbehaved");

  normal_idle_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (pending_status_out[31:1] & s_q.mask[31:1]) == 31'h0 |=> !normal_request_out)
    else $error("normal line raised with nothing enabled pending");
endmodule : irq_cmd_regs

/* sim/core_model.sv */
// Behavioural core that acknowledges the normal request line
`timescale 1ns/1ns
module core_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Behaviour control from the bench
  input  wire logic       ack_en_in,
  input  wire logic [3:0] delay_in,
  // Request line and acknowledge pulse
  input  wire logic       normal_line_in,
  output logic            ack_out
);
  logic [3:0] wait_q;

  // Count down after the line is seen, then pulse once; larger delay acts as a slow core
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q  <= 4'h0;
      ack_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      if (wait_q != 4'h0) begin
        wait_q  <= wait_q - 4'h1;
        ack_out <= (wait_q == 4'h1);
      end else if (ack_en_in && normal_line_in && !ack_out) begin
        wait_q <= delay_in; // Delay of zero never acknowledges
      end
    end
  end
endmodule : core_model

/* sim/tb_interrupt_mask_and_command_regs.sv */
// Self-checking bench for the interrupt mask and command register slice
`timescale 1ns/1ns
module tb_interrupt_mask_and_command_regs;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] trig     = 32'h0000_0000;
  logic        ack_en   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ack;
  logic        fast_line;
  logic        norm_line;
  logic [31:0] pend;
  logic [2:0]  level;
  logic        irq;
  int          err_total = 0;
  int          tests_run = 0;

  // Clock at 50 MHz
  always #10 clk_in = ~clk_in;

  irq_cmd_regs u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .source_trig_in(trig),
    .source_prio_in(96'h28), .vector_ack_in(ack), .fast_request_out(fast_line),
    .normal_request_out(norm_line), .pending_status_out(pend),
    .current_level_out(level), .irq_out(irq));

  // Source 1 sits at level 5; a two-cycle acknowledge delay
  core_model u_core (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ack_en_in(ack_en), .delay_in(4'h2),
    .normal_line_in(norm_line), .ack_out(ack));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t bus transfer timed out", $time);
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  // Let the edges land, then sample settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(irq_cmd_pkg::ENABLE_MASK_OFS, 32'h0000_0000);
    rd(irq_cmd_pkg::LINE_STATUS_OFS, 32'h0000_0000);
    chk(pend, 32'h0000_0000);
    apb(1'b0, 12'h118, 32'h0, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    $display("test reset done");
  endtask : t_reset

  // Walk each source bit through enable and disable
  task automatic t_mask;
    for (int i = 0; i < 32; i++) begin
      wr(irq_cmd_pkg::ENABLE_CMD_OFS, 32'h1 << i);
      rd(irq_cmd_pkg::ENABLE_MASK_OFS, (i == 21 || i == 22) ? 32'h0 : 32'h1 << i);
      wr(irq_cmd_pkg::DISABLE_CMD_OFS, 32'h1 << i);
    end
    wr(irq_cmd_pkg::ENABLE_CMD_OFS, 32'hFFFF_FFFF);
    rd(irq_cmd_pkg::ENABLE_MASK_OFS, 32'hFF9F_FFFF);
    wr(irq_cmd_pkg::DISABLE_CMD_OFS, 32'h0000_FFFF);
    rd(irq_cmd_pkg::ENABLE_MASK_OFS, 32'hFF9F_0000);
    wr(irq_cmd_pkg::ENABLE_MASK_OFS, 32'h0000_0000);
    rd(irq_cmd_pkg::ENABLE_MASK_OFS, 32'hFF9F_0000);
    wr(irq_cmd_pkg::DISABLE_CMD_OFS, 32'hFFFF_FFFF);
    rd(irq_cmd_pkg::ENABLE_MASK_OFS, 32'h0000_0000);
    $display("test mask done");
  endtask : t_mask

  task automatic t_pending;
    wr(irq_cmd_pkg::PEND_SET_OFS, 32'hFFFF_FFFF);
    tick(2);
    chk(pend, 32'hFF9F_FFFF);
    wr(irq_cmd_pkg::PEND_CLEAR_OFS, 32'h0F0F_0F0F);
    tick(2);
    chk(pend, 32'hF090_F0F0);
    rd(irq_cmd_pkg::PEND_STATUS_OFS, 32'hF090_F0F0);
    wr(irq_cmd_pkg::PEND_CLEAR_OFS, 32'hFFFF_FFFF);
    @(posedge clk_in);
    trig <= 32'h0000_0020;
    @(posedge clk_in);
    trig <= 32'h0000_0000;
    tick(2);
    chk(pend, 32'h0000_0020);
    wr(irq_cmd_pkg::PEND_CLEAR_OFS, 32'h0000_0020);
    tick(2);
    chk(pend, 32'h0000_0000);
    $display("test pending done");
  endtask : t_pending

  // Fast line, then a normal request acknowledged and ended by software
  task automatic t_lines;
    int n;
    wr(irq_cmd_pkg::ENABLE_CMD_OFS, 32'h0000_0003);
    wr(irq_cmd_pkg::PEND_SET_OFS, 32'h0000_0001);
    tick(3);
    chk({31'h0, fast_line}, 32'h0000_0001);
    rd(irq_cmd_pkg::LINE_STATUS_OFS, 32'h0000_0001);
    wr(irq_cmd_pkg::PEND_CLEAR_OFS, 32'h0000_0001);
    tick(3);
    chk({31'h0, fast_line}, 32'h0000_0000);
    @(posedge clk_in);
    ack_en <= 1'b1;
    wr(irq_cmd_pkg::EVENT_MASK_OFS, 32'h0000_0001);
    wr(irq_cmd_pkg::PEND_SET_OFS, 32'h0000_0002);
    for (n = 0; n < 20 && level !== 3'h5; n++) @(posedge clk_in);
    chk({29'h0, level}, 32'h0000_0005);
    rd(irq_cmd_pkg::LEVEL_OFS, 32'h0000_0015);
    tick(2);
    chk({30'h0, norm_line, irq}, 32'h0000_0000);
    @(posedge clk_in);
    ack_en <= 1'b0;
    wr(irq_cmd_pkg::END_TREAT_OFS, 32'hA5A5_0000);
    tick(3);
    chk({29'h0, level}, 32'h0000_0000);
    chk({30'h0, norm_line, irq}, 32'h0000_0003);
    wr(irq_cmd_pkg::EVENT_STATUS_OFS, 32'h0000_0001);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    // End of treatment with an empty stack: no pop, event still flagged
    wr(irq_cmd_pkg::END_TREAT_OFS, 32'h0000_0000);
    rd(irq_cmd_pkg::LEVEL_OFS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(irq_cmd_pkg::PEND_CLEAR_OFS, 32'hFFFF_FFFF);
    wr(irq_cmd_pkg::DISABLE_CMD_OFS, 32'hFFFF_FFFF);
    $display("test lines done");
  endtask : t_lines

  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    t_reset();
    t_mask();
    t_pending();
    t_lines();
    stop_test();
  end
endmodule : tb_interrupt_mask_and_command_regs
